// *** rtl/csm_map.svh ***
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH

// Register byte addresses on the bus.
`define CSM_ADDR_CTRL 8'h00
`define CSM_ADDR_STAT 8'h04

// Field positions in the oscillator control register.
`define CSM_TRIM_HI_LSB 14
`define CSM_CUR_LSB 12
`define CSM_TRIM_LO_LSB 10
`define CSM_NEW_LSB 8
`define CSM_LOCK_BIT 5
`define CSM_FAIL_BIT 3
`define CSM_SWITCH_BIT 0

// Field positions in the status register.
`define CSM_ST_SLOW_ON_BIT 0
`define CSM_ST_SYSTEM_RESET_INTERNAL_BIT 1
`define CSM_ST_OSC_READY_BIT 2
`define CSM_ST_SW_BUSY_BIT 3
`define CSM_ST_POWERUP_TIMER_DONE_BIT 4

// Unlock keys, written as two byte writes in a row.
`define CSM_KEY_LO_1 8'h46
`define CSM_KEY_LO_2 8'h57
`define CSM_KEY_HI_1 8'h78
`define CSM_KEY_HI_2 8'h9A

// Reset values.
`define CSM_TRIM_RESET 4'h0
`define CSM_CTRL_RESET 16'h0000

// Bus encodings.
`define CSM_HSIZE_BYTE 3'h0

// Timing, each figure in its own unit with the derived count.
`define CSM_CLK_MHZ 200
`define CSM_POR_DELAY_US 10
`define CSM_POR_CYC (`CSM_POR_DELAY_US * `CSM_CLK_MHZ)
`define CSM_SLOW_RC_KHZ 512
`define CSM_POWERUP_TIMER_A_MS 4
`define CSM_POWERUP_TIMER_B_MS 16
`define CSM_POWERUP_TIMER_C_MS 64
`define CSM_POWERUP_TIMER_A_TICKS (`CSM_POWERUP_TIMER_A_MS * `CSM_SLOW_RC_KHZ)
`define CSM_POWERUP_TIMER_B_TICKS (`CSM_POWERUP_TIMER_B_MS * `CSM_SLOW_RC_KHZ)
`define CSM_POWERUP_TIMER_C_TICKS (`CSM_POWERUP_TIMER_C_MS * `CSM_SLOW_RC_KHZ)
`define CSM_MASTER_CLEAR_PIN_FILT_NS 100
`define CSM_MASTER_CLEAR_PIN_FILT_CYC (`CSM_MASTER_CLEAR_PIN_FILT_NS * `CSM_CLK_MHZ / 1000)
`define CSM_OST_CYC 1024
`define CSM_FAIL_TICKS 4
`define CSM_SWITCH_CYC 8

`endif

// *** rtl/csm_pkg.sv ***
package csm_pkg;

  // Oscillator groups as coded in the group fields and fuses.
  typedef enum logic [1:0] {
    GRP_SECONDARY = 2'h0,
    GRP_FAST_RC = 2'h1,
    GRP_SLOW_RC = 2'h2,
    GRP_PRIMARY = 2'h3
  } csm_group_t;

  // Clock switch sequencer states.
  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_RUN = 2'b10
  } csm_sw_state_t;

  // Reset release sequencer states.
  typedef enum logic [3:0] {
    RST_POR = 4'b0001,
    RST_POWERUP_TIMER = 4'b0010,
    RST_PHASE = 4'b0100,
    RST_RUN = 4'b1000
  } csm_rst_state_t;

endpackage

// *** rtl/csm_reset_seq.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.svh"

module csm_reset_seq #(
  parameter int unsigned POWERUP_TIMER_A_TICKS = `CSM_POWERUP_TIMER_A_TICKS,
  parameter int unsigned POWERUP_TIMER_B_TICKS = `CSM_POWERUP_TIMER_B_TICKS,
  parameter int unsigned POWERUP_TIMER_C_TICKS = `CSM_POWERUP_TIMER_C_TICKS
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow_tick,
  input wire logic first_phase_tick,
  input wire logic brownout_reset,
  input wire logic master_clear_pin_i,
  input wire logic [1:0] powerup_timer_sel,
  output logic powerup_timer_done,
  output logic powerup_timer_expire,
  output logic system_reset_internal,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe
);

  csm_pkg::csm_rst_state_t state_reg;
  csm_pkg::csm_rst_state_t state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0] master_clear_pin_cnt_reg;
  wire [15:0] powerup_timer_limit;
  wire master_clear_pin_hold;
  wire por_last;
  wire powerup_timer_last;

  // Short low pulses on the master clear pin never reach the hold.
  assign master_clear_pin_hold = (master_clear_pin_cnt_reg == 8'(`CSM_MASTER_CLEAR_PIN_FILT_CYC));
  assign powerup_timer_limit = (powerup_timer_sel == 2'h0) ? 16'h0000 :
                      (powerup_timer_sel == 2'h1) ? 16'(POWERUP_TIMER_A_TICKS) :
                      (powerup_timer_sel == 2'h2) ? 16'(POWERUP_TIMER_B_TICKS) :
                      16'(POWERUP_TIMER_C_TICKS);
  assign por_last = (cnt_reg == 16'(`CSM_POR_CYC - 1));
  assign powerup_timer_last = (cnt_reg >= powerup_timer_limit);

  // Bias delay first, then the selectable timeout on slow RC ticks.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      csm_pkg::RST_POR:
      begin
        cnt_next = por_last ? 16'h0000 : cnt_reg + 16'h0001;
        if (por_last)
          state_next = csm_pkg::RST_POWERUP_TIMER;
      end
      csm_pkg::RST_POWERUP_TIMER:
      begin
        if (powerup_timer_last)
          state_next = csm_pkg::RST_PHASE;
        else if (slow_tick)
          cnt_next = cnt_reg + 16'h0001;
      end
      csm_pkg::RST_PHASE:
      begin
        if (first_phase_tick && !master_clear_pin_hold)
          state_next = csm_pkg::RST_RUN;
      end
      csm_pkg::RST_RUN:
      begin
        if (master_clear_pin_hold)
          state_next = csm_pkg::RST_PHASE;
      end
      default:
      begin
        state_next = csm_pkg::RST_POR;
        cnt_next = 16'h0000;
      end
    endcase
    if (brownout_reset)
    begin
      state_next = csm_pkg::RST_POR;
      cnt_next = 16'h0000;
    end
  end

  // The pin is only ever sensed; internal resets never pull it low.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= csm_pkg::RST_POR;
      cnt_reg <= 16'h0000;
      master_clear_pin_cnt_reg <= 8'h00;
      powerup_timer_done <= 1'b0;
      powerup_timer_expire <= 1'b0;
      system_reset_internal <= 1'b1;
      master_clear_pin_o <= 1'b0;
      master_clear_pin_oe <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      master_clear_pin_cnt_reg <= master_clear_pin_i ? 8'h00 :
                      master_clear_pin_hold ? master_clear_pin_cnt_reg : master_clear_pin_cnt_reg + 8'h01;
      powerup_timer_done <= !brownout_reset && (powerup_timer_done ||
                   (state_reg == csm_pkg::RST_POWERUP_TIMER && powerup_timer_last));
      powerup_timer_expire <= !brownout_reset && state_reg == csm_pkg::RST_POWERUP_TIMER &&
                     powerup_timer_last;
      system_reset_internal <= (state_next != csm_pkg::RST_RUN);
    end
  end

  chk_release_phase_edge:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == csm_pkg::RST_PHASE && first_phase_tick && !master_clear_pin_hold &&
       !brownout_reset) |=> !system_reset_internal ##0 $past(powerup_timer_done))
    else $error("Internal reset not released on first phase edge.");

  chk_pin_never_driven:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (master_clear_pin_i ##1 !master_clear_pin_i ##1 master_clear_pin_i)
      |-> !master_clear_pin_hold && !master_clear_pin_oe)
    else $error("Short master clear pulse passed or pin driven.");

endmodule
`default_nettype wire

// *** rtl/csm_clock_ctrl.sv ***
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.svh"

module csm_clock_ctrl #(
  parameter int unsigned POWERUP_TIMER_A_TICKS = `CSM_POWERUP_TIMER_A_TICKS,
  parameter int unsigned POWERUP_TIMER_B_TICKS = `CSM_POWERUP_TIMER_B_TICKS,
  parameter int unsigned POWERUP_TIMER_C_TICKS = `CSM_POWERUP_TIMER_C_TICKS
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] monitor_switch_config,
  input wire logic [1:0] reset_group_config,
  input wire logic [3:0] primary_mode_config,
  input wire logic [1:0] powerup_timeout_sel,
  input wire logic watchdog_fuse_enable,
  input wire logic soft_watchdog_enable,
  input wire logic sleep_mode,
  input wire logic brownout_reset,
  input wire logic master_clear_pin_i,
  input wire logic first_phase_tick,
  input wire logic slow_rc_tick,
  input wire logic sys_clk_tick,
  input wire logic osc_cycle_tick,
  input wire logic pll_lock,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe,
  output logic system_reset_internal,
  output logic slow_rc_enable,
  output logic watchdog_tick,
  output logic fast_rc_select,
  output logic [3:0] fast_rc_trim,
  output logic [1:0] sys_group_sel,
  output logic [3:0] primary_mode_sel,
  output logic osc_clock_release,
  output logic clock_fail_trap
);

  // Crystal sources must run out the start-up timer before use.
  function automatic logic is_crystal(input logic [1:0] grp,
                                      input logic [3:0] mode);
    is_crystal = (grp == csm_pkg::GRP_SECONDARY) ||
                 (grp == csm_pkg::GRP_PRIMARY && !mode[3]);
  endfunction

  // PLL modes of the primary group need lock before release.
  function automatic logic uses_pll(input logic [1:0] grp,
                                    input logic [3:0] mode);
    uses_pll = (grp == csm_pkg::GRP_PRIMARY) && mode[2] &&
               (mode[1:0] != 2'h0);
  endfunction

  logic dp_wr_reg;
  logic dp_act_reg;
  logic [7:0] dp_addr_reg;
  logic [2:0] dp_size_reg;
  logic [1:0] current_group_reg;
  logic [1:0] new_group_reg;
  logic [3:0] trim_reg;
  logic clock_fail_reg;
  logic switch_reg;
  logic lo_key_reg;
  logic lo_open_reg;
  logic hi_key_reg;
  logic hi_open_reg;
  logic sleep_q_reg;
  logic fuse_load_reg; // First cycle after reset loads groups from fuses.
  logic [2:0] miss_reg;
  logic [10:0] ost_reg;
  logic [3:0] sw_cnt_reg;
  csm_pkg::csm_sw_state_t sw_state_reg;
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;
  wire powerup_timer_done;
  wire powerup_timer_expire;
  wire take;
  wire ctrl_wr;
  wire lo_wr;
  wire hi_wr;
  wire lo_take;
  wire hi_take;
  wire [15:0] wdata16;
  wire [7:0] lo_byte;
  wire [7:0] hi_byte;
  wire switch_allowed;
  wire mon_en;
  wire mon_active;
  wire fail_evt;
  wire sw_set;
  wire sw_clr;
  wire sw_last;
  wire sw_done;
  wire ost_restart;
  wire ost_done;
  wire osc_ready;
  wire wdt_on;
  wire slow_tick;
  wire [31:0] read_word;
  wire [1:0] current_next;
  wire [1:0] new_next;
  wire [3:0] trim_next;
  wire clock_fail_next;
  wire switch_next;
  wire lo_key_next;
  wire lo_open_next;
  wire hi_key_next;
  wire hi_open_next;
  wire [2:0] miss_next;
  wire [10:0] ost_next;
  wire slow_rc_enable_next;
  csm_pkg::csm_sw_state_t sw_state_next;

  // Power-on delay, power-up timeout and master clear handling.
  csm_reset_seq #(
    .POWERUP_TIMER_A_TICKS(POWERUP_TIMER_A_TICKS),
    .POWERUP_TIMER_B_TICKS(POWERUP_TIMER_B_TICKS),
    .POWERUP_TIMER_C_TICKS(POWERUP_TIMER_C_TICKS)
  ) u_reset_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .slow_tick(slow_tick),
    .first_phase_tick(first_phase_tick),
    .brownout_reset(brownout_reset),
    .master_clear_pin_i(master_clear_pin_i),
    .powerup_timer_sel(powerup_timeout_sel),
    .powerup_timer_done(powerup_timer_done),
    .powerup_timer_expire(powerup_timer_expire),
    .system_reset_internal(system_reset_internal),
    .master_clear_pin_o(master_clear_pin_o),
    .master_clear_pin_oe(master_clear_pin_oe)
  );

  // Bus decode: zero wait states, so every data phase completes at once.
  assign take = hsel && htrans[1] && hready;
  assign ctrl_wr = dp_wr_reg && ({dp_addr_reg[7:2], 2'b00} == `CSM_ADDR_CTRL);
  assign lo_wr = ctrl_wr && (dp_size_reg == `CSM_HSIZE_BYTE) &&
                 (dp_addr_reg[1:0] == 2'h0);
  assign hi_wr = ctrl_wr && (dp_size_reg == `CSM_HSIZE_BYTE) &&
                 (dp_addr_reg[1:0] == 2'h1);
  assign wdata16 = hwdata[15:0];
  assign lo_byte = wdata16[7:0];
  assign hi_byte = wdata16[15:8];
  assign lo_take = lo_wr && lo_open_reg;
  assign hi_take = hi_wr && hi_open_reg;

  // Each completed transfer either advances a key or cancels it.
  assign lo_key_next = dp_act_reg ?
    (lo_wr && !lo_open_reg && lo_byte == `CSM_KEY_LO_1) : lo_key_reg;
  assign lo_open_next = dp_act_reg ?
    (lo_wr && lo_key_reg && lo_byte == `CSM_KEY_LO_2) : lo_open_reg;
  assign hi_key_next = dp_act_reg ?
    (hi_wr && !hi_open_reg && hi_byte == `CSM_KEY_HI_1) : hi_key_reg;
  assign hi_open_next = dp_act_reg ?
    (hi_wr && hi_key_reg && hi_byte == `CSM_KEY_HI_2) : hi_open_reg;

  // Configuration 1x turns off both switching and monitoring.
  assign switch_allowed = !monitor_switch_config[1];
  assign mon_en = (monitor_switch_config == 2'h0);

  // A silent system clock for several slow RC ticks is a failure.
  assign mon_active = mon_en && powerup_timer_done && !sleep_mode &&
                      (current_group_reg != csm_pkg::GRP_FAST_RC);
  assign miss_next = (sys_clk_tick || !mon_active) ? 3'h0 :
                     (slow_tick && miss_reg != 3'(`CSM_FAIL_TICKS)) ?
                     miss_reg + 3'h1 : miss_reg;
  assign fail_evt = (mon_active && miss_reg == 3'(`CSM_FAIL_TICKS)) ||
                    (powerup_timer_expire && mon_en && !osc_ready);

  // Switch requests only move between whole groups.
  assign sw_set = lo_take && lo_byte[`CSM_SWITCH_BIT] && !switch_reg &&
                  switch_allowed;
  assign sw_clr = lo_take && !lo_byte[`CSM_SWITCH_BIT];
  assign sw_last = (sw_cnt_reg == 4'(`CSM_SWITCH_CYC - 1));
  assign sw_done = (sw_state_reg == csm_pkg::SW_RUN) && sw_last &&
                   !fail_evt && !sw_clr;

  // Failure wins over a completing switch and over a software set.
  assign current_next = (brownout_reset || fuse_load_reg ||
                         !switch_allowed) ? reset_group_config :
                        fail_evt ? csm_pkg::GRP_FAST_RC :
                        sw_done ? new_group_reg : current_group_reg;
  assign new_next = (brownout_reset || fuse_load_reg) ?
                    reset_group_config :
                    hi_take ? wdata16[`CSM_NEW_LSB +: 2] : new_group_reg;
  assign trim_next = hi_take ? {wdata16[`CSM_TRIM_HI_LSB +: 2],
                                wdata16[`CSM_TRIM_LO_LSB +: 2]} :
                     trim_reg;
  assign clock_fail_next = !brownout_reset &&
                           (fail_evt || clock_fail_reg);
  assign switch_next = !fail_evt && !sw_done && !sw_clr && switch_allowed &&
                       (sw_set || switch_reg);

  // Start-up timer restarts whenever the oscillator has to restart.
  assign ost_restart = brownout_reset || (sleep_q_reg && !sleep_mode) ||
                       sw_done;
  assign ost_done = (ost_reg == 11'(`CSM_OST_CYC));
  assign ost_next = ost_restart ? 11'h000 :
                    (osc_cycle_tick && !ost_done) ? ost_reg + 11'h001 :
                    ost_reg;
  assign osc_ready =
    (!is_crystal(current_group_reg, primary_mode_config) || ost_done) &&
    (!uses_pll(current_group_reg, primary_mode_config) || pll_lock);

  // The watchdog bit has no say while the monitor needs the slow RC.
  assign wdt_on = watchdog_fuse_enable || soft_watchdog_enable;
  assign slow_rc_enable_next = !powerup_timer_done || (mon_en && !sleep_mode) ||
    wdt_on || (current_next == csm_pkg::GRP_SLOW_RC);
  assign slow_tick = slow_rc_tick && slow_rc_enable;

  // Read views use next values so a read right after a write is current.
  always_comb
  begin
    ctrl_view = `CSM_CTRL_RESET;
    ctrl_view[`CSM_TRIM_HI_LSB +: 2] = trim_next[3:2];
    ctrl_view[`CSM_CUR_LSB +: 2] = current_next;
    ctrl_view[`CSM_TRIM_LO_LSB +: 2] = trim_next[1:0];
    ctrl_view[`CSM_NEW_LSB +: 2] = new_next;
    ctrl_view[`CSM_LOCK_BIT] = pll_lock;
    ctrl_view[`CSM_FAIL_BIT] = clock_fail_next;
    ctrl_view[`CSM_SWITCH_BIT] = switch_next;
    stat_view = 16'h0000;
    stat_view[`CSM_ST_SLOW_ON_BIT] = slow_rc_enable_next;
    stat_view[`CSM_ST_SYSTEM_RESET_INTERNAL_BIT] = system_reset_internal;
    stat_view[`CSM_ST_OSC_READY_BIT] = osc_ready;
    stat_view[`CSM_ST_SW_BUSY_BIT] = (sw_state_next == csm_pkg::SW_RUN);
    stat_view[`CSM_ST_POWERUP_TIMER_DONE_BIT] = powerup_timer_done;
  end

  assign read_word = (haddr[7:0] == `CSM_ADDR_CTRL) ? {16'h0000, ctrl_view} :
                     (haddr[7:0] == `CSM_ADDR_STAT) ? {16'h0000, stat_view} :
                     32'h0000_0000;

  // Switch sequencer: a fixed settle time, abortable by software.
  always_comb
  begin
    sw_state_next = sw_state_reg;
    case (sw_state_reg)
      csm_pkg::SW_IDLE:
      begin
        if (sw_set && !fail_evt)
          sw_state_next = csm_pkg::SW_RUN;
      end
      csm_pkg::SW_RUN:
      begin
        if (fail_evt || sw_clr || sw_last || !switch_allowed)
          sw_state_next = csm_pkg::SW_IDLE;
      end
      default:
        sw_state_next = csm_pkg::SW_IDLE;
    endcase
  end

  // Bus side registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_reg <= 1'b0;
      dp_act_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      dp_size_reg <= 3'h0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dp_wr_reg <= take && hwrite;
      dp_act_reg <= take;
      dp_addr_reg <= take ? haddr[7:0] : dp_addr_reg;
      dp_size_reg <= take ? hsize : dp_size_reg;
      hrdata <= (take && !hwrite) ? read_word : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Oscillator control state; groups reset to fast RC, then load the reset fuse default.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      current_group_reg <= csm_pkg::GRP_FAST_RC;
      new_group_reg <= csm_pkg::GRP_FAST_RC;
      trim_reg <= `CSM_TRIM_RESET;
      clock_fail_reg <= 1'b0;
      switch_reg <= 1'b0;
      lo_key_reg <= 1'b0;
      lo_open_reg <= 1'b0;
      hi_key_reg <= 1'b0;
      hi_open_reg <= 1'b0;
      sw_state_reg <= csm_pkg::SW_IDLE;
      sw_cnt_reg <= 4'h0;
      fuse_load_reg <= 1'b1;
    end
    else
    begin
      current_group_reg <= current_next;
      new_group_reg <= new_next;
      trim_reg <= trim_next;
      clock_fail_reg <= clock_fail_next;
      switch_reg <= switch_next;
      lo_key_reg <= lo_key_next;
      lo_open_reg <= lo_open_next;
      hi_key_reg <= hi_key_next;
      hi_open_reg <= hi_open_next;
      sw_state_reg <= sw_state_next;
      fuse_load_reg <= 1'b0;
      sw_cnt_reg <= (sw_state_reg == csm_pkg::SW_RUN) ? sw_cnt_reg + 4'h1 :
                    4'h0;
    end
  end

  // Monitor, timers and the registered outputs toward the clock tree.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sleep_q_reg <= 1'b0;
      miss_reg <= 3'h0;
      ost_reg <= 11'h000;
      slow_rc_enable <= 1'b1;
      watchdog_tick <= 1'b0;
      fast_rc_select <= 1'b0;
      fast_rc_trim <= `CSM_TRIM_RESET;
      sys_group_sel <= csm_pkg::GRP_FAST_RC;
      primary_mode_sel <= 4'h0;
      osc_clock_release <= 1'b0;
      clock_fail_trap <= 1'b0;
    end
    else
    begin
      sleep_q_reg <= sleep_mode;
      miss_reg <= miss_next;
      ost_reg <= ost_next;
      slow_rc_enable <= slow_rc_enable_next;
      watchdog_tick <= slow_tick && wdt_on;
      fast_rc_select <= (current_next == csm_pkg::GRP_FAST_RC);
      fast_rc_trim <= trim_next;
      sys_group_sel <= current_next;
      primary_mode_sel <= primary_mode_config;
      osc_clock_release <= osc_ready && !fuse_load_reg;
      clock_fail_trap <= fail_evt;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_fail;
    fail_evt && !brownout_reset && switch_allowed;
  endsequence

  sequence s_low_key_pair;
    lo_wr && lo_key_reg && lo_byte == `CSM_KEY_LO_2;
  endsequence

  chk_fail_fast_switch:
    assert property (s_fail |=> current_group_reg == csm_pkg::GRP_FAST_RC &&
                     clock_fail_reg && !switch_reg && fast_rc_select)
    else $error("Failure did not switch to fast RC.");

  chk_fail_trap_pulse:
    assert property (fail_evt |=> clock_fail_trap ##1 !clock_fail_trap)
    else $error("Trap pulse wrong after failure.");

  chk_low_key_open:
    assert property (s_low_key_pair |=> (lo_open_reg and
                     (dp_act_reg |=> !lo_open_reg)))
    else $error("Low byte unlock not opened for one access.");

  chk_high_locked:
    assert property (hi_wr && !hi_open_reg && !brownout_reset |=>
                     $stable(trim_reg) &&
                     $stable(new_group_reg))
    else $error("Locked high byte accepted a write.");

  chk_unlock_cancel:
    assert property (lo_key_reg && dp_act_reg && !lo_wr |=> !lo_open_reg)
    else $error("Unlock survived an intervening access.");

  chk_switch_disabled:
    assert property (monitor_switch_config[1] && !brownout_reset |=>
                     !switch_reg && !clock_fail_trap &&
                     current_group_reg == $past(reset_group_config))
    else $error("Switching active while disabled.");

  chk_switch_abort:
    assert property (sw_state_reg == csm_pkg::SW_RUN && sw_clr && !fail_evt &&
                     !brownout_reset && switch_allowed |=>
                     sw_state_reg == csm_pkg::SW_IDLE && !switch_reg &&
                     $stable(current_group_reg))
    else $error("Clearing the switch bit did not abort.");

  chk_pll_hold:
    assert property (uses_pll(current_group_reg, primary_mode_config) &&
                     !pll_lock |=> !osc_clock_release)
    else $error("Clock released before PLL lock.");

  chk_slow_rc_early:
    assert property (!powerup_timer_done |=> slow_rc_enable)
    else $error("Slow RC off before power-up timer expired.");

endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "csm_map.svh"
`define CHK(g,e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pll_lock;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, monitor_switch_config, reset_group_config;
  logic [1:0] powerup_timeout_sel, sys_group_sel;
  logic [2:0] hsize;
  logic [3:0] primary_mode_config, fast_rc_trim, primary_mode_sel, trim;
  logic watchdog_fuse_enable, soft_watchdog_enable, sleep_mode, sys_run;
  logic brownout_reset, master_clear_pin_i, first_phase_tick, slow_rc_tick;
  logic sys_clk_tick, osc_cycle_tick, master_clear_pin_o, osc_clock_release;
  logic master_clear_pin_oe, system_reset_internal, slow_rc_enable;
  logic watchdog_tick, fast_rc_select, clock_fail_trap;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int i;
  assign hready = hreadyout;
  csm_clock_ctrl #(.POWERUP_TIMER_A_TICKS(4), .POWERUP_TIMER_B_TICKS(8), .POWERUP_TIMER_C_TICKS(16))
    uut (.*);
  // Short counts keep the run brief; every wait below is bounded except the hready loops in bus.
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Free-running tick sources; system clock edges stop to fake a failure.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    slow_rc_tick <= (cyc % 8 == 0);
    first_phase_tick <= (cyc % 4 == 1);
    osc_cycle_tick <= cyc[0];
    sys_clk_tick <= sys_run;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One single transfer; the address phase holds until hready is seen.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= w ? `CSM_HSIZE_BYTE : 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wb(input logic [7:0] a, input logic [7:0] b);
    bus(1'b1, a, {4{b}});
  endtask
  task automatic rdc;
    bus(1'b0, `CSM_ADDR_CTRL, 32'h0);
  endtask
  task automatic wait_rel;
    for (i = 0; i < 4000 && system_reset_internal !== 1'b0; i++)
      @(posedge hclk);
    `CHK(system_reset_internal, 1'b0)
  endtask
  function automatic logic [7:0] hi_exp(logic [3:0] t, logic [1:0] c,
                                        logic [1:0] n);
    return {t[3:2], c, t[1:0], n};
  endfunction
  // Crystal groups hold the clock until the start-up timer has run out.
  function automatic logic rel_exp();
    return !(reset_group_config == 2'h0 ||
             (reset_group_config == 2'h3 && !primary_mode_config[3]));
  endfunction
  // Watchdog against a hang anywhere in the sequence.
  initial
  begin
    #(5 * 30000);
    miscompares++;
    final_report();
  end
  // Main sequence: fuse selection, unlock keys, switch, failure, then master clear.
  initial
  begin
    trim = 4'($urandom(29619));
    {hresetn, hwrite, htrans, haddr, hwdata, hsize} = '0;
    {brownout_reset, soft_watchdog_enable, watchdog_fuse_enable} = '0;
    {sleep_mode, hsel, master_clear_pin_i, pll_lock, sys_run} = 5'h0F;
    primary_mode_config = 4'($urandom);
    powerup_timeout_sel = 2'($urandom);
    reset_group_config = 2'($urandom);
    monitor_switch_config = {1'b1, 1'($urandom)};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    `CHK(slow_rc_enable, 1'b1)
    `CHK(master_clear_pin_oe, 1'b0)
    `CHK(sys_group_sel, reset_group_config)
    `CHK(fast_rc_select, reset_group_config == 2'h1)
    `CHK(primary_mode_sel, primary_mode_config)
    `CHK(osc_clock_release, rel_exp())
    `CHK({hresp, hreadyout, master_clear_pin_o}, 3'b010)
    wait_rel();
    rdc();
    `CHK(rd[13:8], {reset_group_config, 2'b00, reset_group_config})
    $display("test fuse selection done");
    @(posedge hclk);
    {monitor_switch_config, reset_group_config, brownout_reset} <= 5'h03;
    @(posedge hclk);
    brownout_reset <= 1'b0;
    repeat (4) @(posedge hclk);
    wait_rel();
    wb(8'h01, 8'hFF);
    wb(8'h01, `CSM_KEY_HI_1);
    rdc();
    wb(8'h01, `CSM_KEY_HI_2);
    wb(8'h01, 8'hFF);
    rdc();
    `CHK(rd[15:8], hi_exp(4'h0, 2'h1, 2'h1))
    wb(8'h01, `CSM_KEY_HI_1);
    wb(8'h01, `CSM_KEY_HI_2);
    // The slow RC group stays above the lowest clock the monitor tolerates.
    wb(8'h01, {trim[3:2], 2'b00, trim[1:0], 2'b10});
    rdc();
    `CHK(rd[15:8], hi_exp(trim, 2'h1, 2'h2))
    `CHK(fast_rc_trim, trim)
    // A read between the low keys must cancel the unlock.
    wb(8'h00, `CSM_KEY_LO_1);
    rdc();
    wb(8'h00, `CSM_KEY_LO_2);
    wb(8'h00, 8'h01);
    rdc();
    `CHK(rd[0], 1'b0)
    wb(8'h00, `CSM_KEY_LO_1);
    wb(8'h00, `CSM_KEY_LO_2);
    wb(8'h00, 8'h01);
    rdc();
    `CHK(rd[0], 1'b1)
    repeat (20) @(posedge hclk);
    rdc();
    `CHK(rd[13:12], 2'h2)
    `CHK(sys_group_sel, 2'h2)
    $display("test unlock and switch done");
    soft_watchdog_enable <= 1'b1;
    sys_run <= 1'b0;
    for (i = 0; i < 200 && clock_fail_trap !== 1'b1; i++) @(posedge hclk);
    `CHK(clock_fail_trap, 1'b1)
    repeat (3) @(posedge hclk);
    #1;
    `CHK(fast_rc_select, 1'b1)
    `CHK(slow_rc_enable, 1'b1)
    `CHK(osc_clock_release, 1'b1)
    rdc();
    `CHK({rd[13:12], rd[3], rd[0]}, 4'b0110)
    for (i = 0; i < 40 && watchdog_tick !== 1'b1; i++) @(posedge hclk);
    `CHK(watchdog_tick, 1'b1)
    $display("test clock failure done");
    // A one-cycle dip is filtered; a long hold resets until released.
    master_clear_pin_i <= 1'b0;
    @(posedge hclk);
    master_clear_pin_i <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK(system_reset_internal, 1'b0)
    master_clear_pin_i <= 1'b0;
    repeat (25) @(posedge hclk);
    `CHK(system_reset_internal, 1'b1)
    master_clear_pin_i <= 1'b1;
    wait_rel();
    $display("test master clear done");
    final_report();
  end
endmodule
`default_nettype wire
